// [device_status_aggregation.v]
/*
 * Device status register bank: main status and supply status.
 * Aggregates signal-processing, link, memory/temperature and supply
 * faults, and keeps the reset-occurred, init and test-state flags.
 * Assumes a single 20 MHz clock, a read strobe with address from the
 * SPI/I2C front end, same-clock fault inputs from the other status
 * blocks, and asynchronous levels from the analog supply monitors.
 */
`timescale 1ns/1ps

`include "status_regs.vh"

module device_status_aggregation #(
    parameter [`INIT_CNT_W-1:0] DATA_VALID_CYCLES = `DATA_VALID_CYCLES_DEF
) (
    input wire sys_clk,
    input wire rst,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    output wire [7:0] reg_rd_data,
    output wire reg_rd_valid,
    input wire status_field_sent,
    input wire selftest_incomplete,
    input wire common_mode_fault,
    input wire selftest_fault,
    input wire readback_mismatch,
    input wire factory_mem_fault,
    input wire user_mem_fault,
    input wire user_reg_check_fault,
    input wire user_mem_write_busy,
    input wire temperature_range_fault,
    input wire test_mode_enter,
    input wire test_mode_exit,
    input wire supply_report_disable,
    input wire undervoltage_raw,
    input wire analog_reg_raw,
    input wire digital_reg_raw,
    input wire memory_reg_raw,
    input wire edge_seal_raw,
    output wire reset_occurred,
    output wire init_in_progress,
    output wire test_state_flag
);

    // Recovery time in cycles, a least time so it rounds up
    localparam [`REC_CNT_W-1:0] RECOVERY_CYCLES = `SUPPLY_RECOVERY_CYCLES;

    // Index of each monitor inside the synchronised supply vector
    localparam UV_IDX = 4;
    localparam ANA_IDX = 3;
    localparam DIG_IDX = 2;
    localparam MEM_IDX = 1;
    localparam SEAL_IDX = 0;

    reg dsp_fault_q;
    reg link_fault_q;
    reg memtemp_fault_q;
    reg test_state_q;
    reg test_state_d;
    reg reset_occ_q;
    reg reset_occ_d;
    reg init_q;
    reg [4:0] supply_flags_q;
    reg [4:0] supply_flags_d;
    reg [7:0] rd_data_q;
    reg rd_valid_q;
    reg [7:0] rd_data_d;

    wire [4:0] supply_raw_async;
    wire [4:0] supply_raw;
    wire supply_fault_now;
    wire recovery_expired;
    wire init_expired;
    wire main_read;
    wire supply_read;
    wire supply_clear;
    wire supply_summary;
    wire [7:0] main_status_reg;
    wire [7:0] supply_status_reg;

    // Analog monitors are asynchronous to sys_clk
    assign supply_raw_async[UV_IDX] = undervoltage_raw;
    assign supply_raw_async[ANA_IDX] = analog_reg_raw;
    assign supply_raw_async[DIG_IDX] = digital_reg_raw;
    assign supply_raw_async[MEM_IDX] = memory_reg_raw;
    assign supply_raw_async[SEAL_IDX] = edge_seal_raw;

    level_sync #(
        .WIDTH(5)
    ) u_supply_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(supply_raw_async),
        .sync_out(supply_raw)
    );

    // Read decode; only the two status offsets are mapped
    assign main_read = reg_rd_en && (reg_addr == `MAIN_STATUS_ADDR);
    assign supply_read = reg_rd_en && (reg_addr == `SUPPLY_STATUS_ADDR);

    // Signal-processing, link and memory summaries, registered
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dsp_fault_q <= `DSP_FAULT_RESET;
            link_fault_q <= `CLEAR_FLAG_RESET;
            memtemp_fault_q <= `CLEAR_FLAG_RESET;
        end
        else
        begin
            dsp_fault_q <= selftest_incomplete | common_mode_fault | selftest_fault;
            link_fault_q <= readback_mismatch;
            memtemp_fault_q <= factory_mem_fault | user_mem_fault | user_reg_check_fault
                | user_mem_write_busy | temperature_range_fault;
        end
    end

    // Test state: only an explicit exit or a reset clears it
    always @*
    begin
        test_state_d = test_state_q;
        if (test_mode_enter)
        begin
            test_state_d = 1'b1;
        end
        else if (test_mode_exit)
        begin
            test_state_d = 1'b0;
        end
    end

    // Reset flag: no hardware set after reset, so clearing never races
    always @*
    begin
        reset_occ_d = reset_occ_q;
        if (main_read || status_field_sent)
        begin
            reset_occ_d = 1'b0;
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            test_state_q <= `CLEAR_FLAG_RESET;
            reset_occ_q <= `RES_FLAG_RESET;
        end
        else
        begin
            test_state_q <= test_state_d;
            reset_occ_q <= reset_occ_d;
        end
    end

    // Data-valid delay runs once from reset and is never reloaded
    cycle_timer #(
        .WIDTH(`INIT_CNT_W),
        .RESET_VALUE(DATA_VALID_CYCLES)
    ) u_init_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(1'b0),
        .load_value(DATA_VALID_CYCLES),
        .expired(init_expired)
    );

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            init_q <= `INIT_FLAG_RESET;
        end
        else if (init_expired)
        begin
            init_q <= 1'b0;
        end
    end

    // One timer for all supply flags, held reloaded while any fault is seen
    assign supply_fault_now = |supply_raw;

    cycle_timer #(
        .WIDTH(`REC_CNT_W),
        .RESET_VALUE({`REC_CNT_W{1'b0}})
    ) u_recovery_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(supply_fault_now),
        .load_value(RECOVERY_CYCLES),
        .expired(recovery_expired)
    );

    // With reporting disabled flags drop at expiry; else a read is needed too
    assign supply_clear = recovery_expired && (supply_report_disable || supply_read);

    // Per-flag set and clear; a fault in the clear cycle keeps the flag
    genvar k;
    generate
        for (k = 0; k < 5; k = k + 1)
        begin : g_supply
            always @*
            begin
                supply_flags_d[k] = supply_flags_q[k];
                if (supply_raw[k])
                begin
                    supply_flags_d[k] = 1'b1;
                end
                else if (supply_clear)
                begin
                    supply_flags_d[k] = 1'b0;
                end
            end
        end
    endgenerate

    // Undefined reset values are taken as clear, which suits bit 0 too
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            supply_flags_q <= `SUPPLY_FLAGS_RESET;
        end
        else
        begin
            supply_flags_q <= supply_flags_d;
        end
    end

    // Supply summary follows the latched flags, not the raw monitors
    assign supply_summary = |supply_flags_q;

    // Main status image; bit 6 reserved and reads zero
    assign main_status_reg[`MS_DSP_BIT] = dsp_fault_q;
    assign main_status_reg[`MS_RSVD_BIT] = 1'b0;
    assign main_status_reg[`MS_LINK_BIT] = link_fault_q;
    assign main_status_reg[`MS_MEMTEMP_BIT] = memtemp_fault_q;
    assign main_status_reg[`MS_SUPPLY_BIT] = supply_summary;
    assign main_status_reg[`MS_TEST_BIT] = test_state_q;
    assign main_status_reg[`MS_RES_BIT] = reset_occ_q;
    assign main_status_reg[`MS_INIT_BIT] = init_q;

    // Supply status image; bits 6 to 4 reserved and read zero
    assign supply_status_reg[`SS_UV_BIT] = supply_flags_q[UV_IDX];
    assign supply_status_reg[`SS_RSVD_HI:`SS_RSVD_LO] = 3'h0;
    assign supply_status_reg[`SS_ANA_BIT] = supply_flags_q[ANA_IDX];
    assign supply_status_reg[`SS_DIG_BIT] = supply_flags_q[DIG_IDX];
    assign supply_status_reg[`SS_MEM_BIT] = supply_flags_q[MEM_IDX];
    assign supply_status_reg[`SS_SEAL_BIT] = supply_flags_q[SEAL_IDX];

    // Read mux; there is no write path, so only reads (read-to-clear) and the hardware alter these
    always @*
    begin
        rd_data_d = `UNMAPPED_DATA;
        case (reg_addr)
            `MAIN_STATUS_ADDR:
            begin
                rd_data_d = main_status_reg;
            end
            `SUPPLY_STATUS_ADDR:
            begin
                rd_data_d = supply_status_reg;
            end
            default:
            begin
                rd_data_d = `UNMAPPED_DATA;
            end
        endcase
    end

    // Data captured before a read-to-clear takes effect
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= `RD_DATA_RESET;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= reg_rd_en;
            if (reg_rd_en)
            begin
                rd_data_q <= rd_data_d;
            end
        end
    end

    assign reg_rd_data = rd_data_q;
    assign reg_rd_valid = rd_valid_q;

    // Flags exported for the status fields of data transfers
    assign reset_occurred = reset_occ_q;
    assign init_in_progress = init_q;
    assign test_state_flag = test_state_q;

endmodule // device_status_aggregation

// [status_regs.vh]
/*
 * Register map, field positions, reset values and timing constants
 * for the device status register bank.
 * Assumes a 20 MHz system clock and an 8-bit register address space.
 */
`ifndef STATUS_REGS_VH
`define STATUS_REGS_VH

// Clock rate in MHz; the cycle counts below are literals worked out for it
`define CLK_MHZ 20

// Register offsets
`define MAIN_STATUS_ADDR 8'h01
`define SUPPLY_STATUS_ADDR 8'h02

// Main status field positions
`define MS_DSP_BIT 7
`define MS_LINK_BIT 5
`define MS_MEMTEMP_BIT 4
`define MS_SUPPLY_BIT 3
`define MS_TEST_BIT 2
`define MS_RES_BIT 1
`define MS_INIT_BIT 0
`define MS_RSVD_BIT 6

// Supply status field positions
`define SS_UV_BIT 7
`define SS_ANA_BIT 3
`define SS_DIG_BIT 2
`define SS_MEM_BIT 1
`define SS_SEAL_BIT 0
`define SS_RSVD_HI 6
`define SS_RSVD_LO 4

// Reset values
`define DSP_FAULT_RESET 1'b1
`define RES_FLAG_RESET 1'b1
`define INIT_FLAG_RESET 1'b1
`define CLEAR_FLAG_RESET 1'b0
`define SUPPLY_FLAGS_RESET 5'h00
`define RD_DATA_RESET 8'h00
`define UNMAPPED_DATA 8'h00

// Timing in cycles: 1000 us data-valid delay, 100 us recovery, at 20 MHz
`define DATA_VALID_CYCLES_DEF 16'h4E20
`define SUPPLY_RECOVERY_CYCLES 16'h07D0

// Counter widths
`define INIT_CNT_W 16
`define REC_CNT_W 16

`endif

// [level_sync.v]
/*
 * Three-stage synchroniser for a group of asynchronous levels.
 * The output follows only once stages two and three agree.
 * Assumes each input is a slowly changing level, not a pulse.
 */
`timescale 1ns/1ps

module level_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;

            // Stage one feeds stage two only, never the agree check
            always @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end
                else
                begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        out_q <= s3_q;
                    end
                end
            end

            assign sync_out[i] = out_q;
        end
    endgenerate

endmodule // level_sync

// [cycle_timer.v]
/*
 * Loadable down counter that stops at zero and flags expiry.
 * Assumes load has priority over counting in the same cycle.
 */
`timescale 1ns/1ps

module cycle_timer #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire rst,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    output wire expired
);

    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;

    // Reload wins; otherwise count down and park at zero
    always @*
    begin
        count_d = count_q;
        if (load)
        begin
            count_d = load_value;
        end
        else if (count_q != {WIDTH{1'b0}})
        begin
            count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= RESET_VALUE;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign expired = (count_q == {WIDTH{1'b0}});

endmodule // cycle_timer

// [status_host.sv]
/* Host model: issues single register reads on the read strobe port.
   Assumes the answer arrives within a few cycles of the request. */
`timescale 1ns/1ps
module status_host (
    input wire sys_clk,
    input wire init_in_progress,
    input wire reg_rd_valid,
    input wire [7:0] reg_rd_data,
    output reg reg_rd_en,
    output reg [7:0] reg_addr,
    output wire sup_trusted
);
    // Supply flags carry no meaning while the device settles
    assign sup_trusted = !init_in_progress;
    initial
    begin
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
    end
    // One read; ok stays low if no answer in four cycles
    task rd(input [7:0] a, output [7:0] d, output ok);
        integer n;
        begin
            ok = 1'b0;
            d = 8'h00;
            @(posedge sys_clk);
            reg_rd_en <= 1'b1;
            reg_addr <= a;
            @(posedge sys_clk);
            reg_rd_en <= 1'b0;
            for (n = 0; n < 4 && !ok; n = n + 1)
            begin
                @(posedge sys_clk);
                if (reg_rd_valid === 1'b1)
                begin
                    d = reg_rd_data;
                    ok = 1'b1;
                end
            end
        end
    endtask
endmodule // status_host

// [device_status_aggregation_props.sv]
/* Concurrent checks on the read port and flags of the status bank.
   Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
module device_status_aggregation_props (
    input wire sys_clk,
    input wire rst,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rd_data,
    input wire reg_rd_valid,
    input wire status_field_sent,
    input wire selftest_incomplete,
    input wire common_mode_fault,
    input wire selftest_fault,
    input wire readback_mismatch,
    input wire test_mode_enter,
    input wire test_mode_exit,
    input wire reset_occurred,
    input wire init_in_progress,
    input wire test_state_flag
);
    reg up_q;
    // Summary images are stale until one clean edge after reset
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            up_q <= 1'b0;
        else
            up_q <= 1'b1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rd_main; reg_rd_en && reg_addr == 8'h01; endsequence
    sequence s_rd_sup; reg_rd_en && reg_addr == 8'h02; endsequence
    property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_unmapped;
        (reg_rd_en && reg_addr != 8'h01 && reg_addr != 8'h02) |=> reg_rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsvd; s_rd_sup |=> reg_rd_data[6:4] == 3'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved supply bits set");
    property p_res_rd; s_rd_main |=> !reset_occurred [*2]; endproperty
    a_res_rd: assert property (p_res_rd) else $error("reset flag kept after read");
    property p_res_sent; status_field_sent |=> !reset_occurred; endproperty
    a_res_sent: assert property (p_res_sent) else $error("reset flag kept after send");
    property p_test_set; test_mode_enter |=> test_state_flag; endproperty
    a_test_set: assert property (p_test_set) else $error("test flag not set");
    property p_test_hold; (test_state_flag && !test_mode_exit) |=> test_state_flag; endproperty
    a_test_hold: assert property (p_test_hold) else $error("test flag dropped");
    property p_dsp;
        (up_q ##0 s_rd_main) |=> reg_rd_data[7] == ($past(selftest_incomplete, 2)
            | $past(common_mode_fault, 2) | $past(selftest_fault, 2));
    endproperty
    a_dsp: assert property (p_dsp) else $error("dsp summary wrong");
    property p_link;
        (up_q ##0 s_rd_main) |=> reg_rd_data[5] == $past(readback_mismatch, 2);
    endproperty
    a_link: assert property (p_link) else $error("link summary wrong");
    property p_init; !init_in_progress |=> !init_in_progress; endproperty
    a_init: assert property (p_init) else $error("init flag set again");
endmodule // device_status_aggregation_props

bind device_status_aggregation device_status_aggregation_props u_props (
    .sys_clk(sys_clk), .rst(rst), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .status_field_sent(status_field_sent), .selftest_incomplete(selftest_incomplete),
    .common_mode_fault(common_mode_fault), .selftest_fault(selftest_fault),
    .readback_mismatch(readback_mismatch), .test_mode_enter(test_mode_enter),
    .test_mode_exit(test_mode_exit), .reset_occurred(reset_occurred),
    .init_in_progress(init_in_progress), .test_state_flag(test_state_flag)
);

// [device_status_aggregation_bench.sv]
/* Self-checking bench for the status register bank with a host model.
   Assumes a short data-valid delay of 20 cycles for run time. */
`timescale 1ns/1ps
module device_status_aggregation_bench;
    reg sys_clk, rst, sent, enter, leave, sup_dis, link, t;
    reg [2:0] dsp;
    reg [4:0] mt, raw;
    reg [31:0] v;
    reg [7:0] e;
    wire rd_en, rd_valid, res_f, init_f, test_f, trust;
    wire [7:0] addr, rd_data;
    integer seed, err_total, num_checks, k, i;
    device_status_aggregation #(.DATA_VALID_CYCLES(16'h0014)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .status_field_sent(sent),
        .selftest_incomplete(dsp[2]), .common_mode_fault(dsp[1]), .selftest_fault(dsp[0]),
        .readback_mismatch(link), .factory_mem_fault(mt[4]), .user_mem_fault(mt[3]),
        .user_reg_check_fault(mt[2]), .user_mem_write_busy(mt[1]),
        .temperature_range_fault(mt[0]), .test_mode_enter(enter), .test_mode_exit(leave),
        .supply_report_disable(sup_dis), .undervoltage_raw(raw[4]), .analog_reg_raw(raw[3]),
        .digital_reg_raw(raw[2]), .memory_reg_raw(raw[1]), .edge_seal_raw(raw[0]),
        .reset_occurred(res_f), .init_in_progress(init_f), .test_state_flag(test_f)
    );
    status_host u_host (
        .sys_clk(sys_clk), .init_in_progress(init_f), .reg_rd_valid(rd_valid),
        .reg_rd_data(rd_data), .reg_rd_en(rd_en), .reg_addr(addr), .sup_trusted(trust)
    );
    always #25 sys_clk = ~sys_clk;
    // Main status image from the expected inputs
    function [7:0] exp_main(input [2:0] d, input l, input [4:0] m, input [3:0] lo);
        exp_main = {|d, 1'b0, l, |m, lo};
    endfunction
    task chk(input [8*10-1:0] what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp)
            begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // A missing answer ends the run at once
    task rdchk(input [7:0] a, input [7:0] exp);
        reg [7:0] d;
        reg ok;
        begin
            u_host.rd(a, d, ok);
            if (!ok)
            begin
                err_total = err_total + 1;
                complete_run;
            end
            else
                chk("read data", exp, d);
        end
    endtask
    initial
    begin
        {sys_clk, sent, enter, leave, sup_dis, link, t, dsp, mt, raw} = 0;
        rst = 1'b1;
        seed = 73;
        err_total = 0;
        num_checks = 0;
        // Read taken at the first edge after release, before bit 7 updates
        repeat (2) @(posedge sys_clk);
        #1 chk("flags", 8'h03, {5'h00, test_f, res_f, init_f});
        fork
            begin
                @(posedge sys_clk);
                rst <= 1'b0;
            end
            rdchk(8'h01, 8'h83);
        join
        #1 chk("flags", 8'h01, {5'h00, test_f, res_f, init_f});
        repeat (20) @(posedge sys_clk);
        #1 chk("flags", 8'h00, {5'h00, test_f, res_f, init_f});
        rdchk(8'h01, 8'h00);
        rdchk(8'h02, 8'h00);
        for (k = 0; k < 4; k = k + 1)
        begin
            v = k * 85;
            rdchk(v[7:0], 8'h00);
        end
        // Enter, exit, then both at once where enter wins
        for (k = 0; k < 3; k = k + 1)
        begin
            @(posedge sys_clk);
            enter <= (k != 1);
            leave <= (k != 0);
            @(posedge sys_clk);
            enter <= 1'b0;
            leave <= 1'b0;
            t = (k != 1);
            #1 chk("test flag", {7'h00, t}, {7'h00, test_f});
        end
        for (k = 0; k < 40; k = k + 1)
        begin
            v = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : $random(seed);
            @(posedge sys_clk);
            dsp <= v[2:0];
            link <= v[3];
            mt <= v[8:4];
            rdchk(8'h01, exp_main(v[2:0], v[3], v[8:4], {1'b0, t, 2'b00}));
        end
        // Last pass clears only by a read once the timer ran out
        for (i = 0; i < 6; i = i + 1)
        begin
            v = 5'h01 << (i % 5);
            e = {v[4], 3'h0, v[3:0]};
            @(posedge sys_clk);
            {dsp, link, mt} <= 9'h000;
            sup_dis <= (i < 5);
            raw <= v[4:0];
            repeat (8) @(posedge sys_clk);
            chk("trusted", 8'h01, {7'h00, trust});
            rdchk(8'h02, e);
            rdchk(8'h01, {5'h01, t, 2'b00});
            @(posedge sys_clk);
            raw <= 5'h00;
            repeat (1000) @(posedge sys_clk);
            rdchk(8'h02, e);
            repeat (1020) @(posedge sys_clk);
            if (i == 5)
                rdchk(8'h02, e);
            rdchk(8'h02, 8'h00);
        end
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk("flags", 8'h03, {5'h00, test_f, res_f, init_f});
        chk("trusted", 8'h00, {7'h00, trust});
        @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        sent <= 1'b1;
        @(posedge sys_clk);
        sent <= 1'b0;
        #1 chk("flags", 8'h01, {5'h00, test_f, res_f, init_f});
        rdchk(8'h01, 8'h01);
        complete_run;
    end
endmodule // device_status_aggregation_bench
